// >>> rtl/dic_pkg.sv
package dic_pkg;
   localparam int WORD_W = 32;
   localparam int ROUTE_ENTRIES = 32;

   // Object subindex map
   localparam logic [7:0] SUB_HIGHEST = 8'h00;
   localparam logic [7:0] SUB_SF_ENABLE = 8'h01;
   localparam logic [7:0] SUB_INVERT = 8'h02;
   localparam logic [7:0] SUB_FORCE_EN = 8'h03;
   localparam logic [7:0] SUB_FORCE_VAL = 8'h04;
   localparam logic [7:0] SUB_RAW = 8'h05;
   localparam logic [7:0] SUB_RANGE = 8'h06;
   localparam logic [7:0] SUB_DIFF = 8'h07;
   localparam logic [7:0] SUB_ROUTE_EN = 8'h08;

   // Reset values and the routing-enable value
   localparam logic [7:0] HIGHEST_ENTRY_RESET = 8'h08;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   localparam logic [31:0] ROUTE_ON_VALUE = 32'h0000_0001;

   // Inputs able to receive differentially
   localparam logic [31:0] DIFF_CAPABLE_MASK = 32'h0000_00FF;

   // Special-function bit positions
   localparam int SF_NEG_LIMIT = 0;
   localparam int SF_POS_LIMIT = 1;
   localparam int SF_HOME = 2;
   localparam int SF_INTERLOCK = 3;

   // Routing selector codes
   localparam logic [7:0] ROUTE_CONST_ZERO = 8'h00;
   localparam logic [7:0] ROUTE_CONST_ONE = 8'h80;
   localparam logic [6:0] ROUTE_PHYS_FIRST = 7'h01;
   localparam logic [6:0] ROUTE_PHYS_LAST = 7'h10;
   localparam logic [6:0] ROUTE_HALL_FIRST = 7'h41;
   localparam logic [6:0] ROUTE_HALL_LAST = 7'h43;
   localparam logic [6:0] ROUTE_ENC_FIRST = 7'h44;
   localparam logic [6:0] ROUTE_ENC_LAST = 7'h46;
   localparam int ROUTE_INVERT_BIT = 7;
endpackage : dic_pkg

// >>> rtl/dic_cond_bit.sv
`timescale 1ns/1ps
`default_nettype none
module dic_cond_bit
   import dic_pkg::*;
(
   input wire logic raw_level,
   input wire logic invert,
   input wire logic clkdir_use,
   input wire logic force_en,
   input wire logic force_val,
   output logic processed
);
   logic polarity_level;

   always_comb begin
      // Clock and direction inputs keep their polarity
      polarity_level = raw_level ^ (invert & ~clkdir_use); // [RULE_05] [RULE_06]
      processed = force_en ? force_val : polarity_level; // [RULE_08] [RULE_09] [RULE_14]
   end
endmodule : dic_cond_bit
`default_nettype wire

// >>> rtl/dic_route_sel.sv
`timescale 1ns/1ps
`default_nettype none
module dic_route_sel
   import dic_pkg::*;
(
   input wire logic [7:0] code,
   input wire logic [31:0] phys_level,
   input wire logic [2:0] hall_level,
   input wire logic [2:0] enc_level,
   output logic routed
);
   logic [6:0] base;
   logic picked;
   logic known;

   always_comb begin
      base = code[6:0];
      picked = 1'b0;
      known = 1'b0;
      if (base == 7'h00) begin
         known = 1'b1; // [RULE_13]
      end else if (base >= ROUTE_PHYS_FIRST && base <= ROUTE_PHYS_LAST) begin
         known = 1'b1;
         picked = phys_level[5'(base - ROUTE_PHYS_FIRST)];
      end else if (base >= ROUTE_HALL_FIRST && base <= ROUTE_HALL_LAST) begin
         known = 1'b1;
         picked = hall_level[2'(base - ROUTE_HALL_FIRST)];
      end else if (base >= ROUTE_ENC_FIRST && base <= ROUTE_ENC_LAST) begin
         known = 1'b1;
         picked = enc_level[2'(base - ROUTE_ENC_FIRST)];
      end
      // Top bit of the code inverts the source; unknown codes give 0
      routed = known & (picked ^ code[ROUTE_INVERT_BIT]); // [RULE_13]
   end
endmodule : dic_route_sel
`default_nettype wire

// >>> rtl/dic_input_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE_01 - Special-function enable bit 1 activates that input's special function, 0 disables it.
// RULE_02 - Enable bits 16 to 31 have no effect on input behaviour.
// RULE_03 - Enable bit 0 negative limit, 1 positive limit, 2 home, 3 interlock.
// RULE_04 - Software clears enable bits of inputs not wired to their special function.
// RULE_05 - Invert bit 0 reports high as 1; invert bit 1 reports high as 0.
// RULE_06 - Inversion applies to normal and special inputs, not clock/direction inputs.
// RULE_07 - Invert bit n controls polarity of input n+1.
// RULE_08 - Force-enable bit 1 replaces the actual input level with the software value.
// RULE_09 - Force-value bit at the same position supplies the forced input value.
// RULE_10 - Raw-value word shows unmodified levels, untouched by inversion, forcing, functions.
// RULE_11 - Differential bit 0 single-ended, 1 differential, only on capable inputs.
// RULE_12 - Routing enable value 1 builds state word through routing instead of direct map.
// RULE_13 - Routed bit code 00 gives 0, 80 gives 1, others pick direct/inverted inputs.
// RULE_14 - Processed input is inverted raw level, then replaced by force value if enabled.
module dic_input_ctrl
   import dic_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [31:0] phys_level,
   input wire logic [2:0] hall_level,
   input wire logic [2:0] enc_level,
   input wire logic [31:0] clkdir_mask,
   input wire logic obj_wr,
   input wire logic obj_rd,
   input wire logic [7:0] obj_subindex,
   input wire logic [31:0] obj_wdata,
   output logic [31:0] obj_rdata,
   output logic obj_rvalid,
   output logic obj_err,
   input wire logic route_wr,
   input wire logic [4:0] route_bit,
   input wire logic [7:0] route_code,
   output logic [31:0] digital_input_state_word,
   output logic neg_limit,
   output logic pos_limit,
   output logic home_switch,
   output logic interlock,
   output logic [31:0] diff_mode_out,
   output logic [31:0] input_range_out
);
   // Control words
   logic [31:0] special_function_enable_mask;
   logic [31:0] polarity_invert_mask;
   logic [31:0] override_enable_mask;
   logic [31:0] override_value_word;
   logic [31:0] unprocessed_input_levels;
   logic [31:0] input_range_choice;
   logic [31:0] differential_mode_mask;
   logic [31:0] source_mapping_on;
   logic [31:0] next_sfe;
   logic [31:0] next_inv;
   logic [31:0] next_fen;
   logic [31:0] next_fval;
   logic [31:0] next_range;
   logic [31:0] next_diff;
   logic [31:0] next_route_on;

   // Object answer
   logic [31:0] next_obj_rdata;
   logic next_obj_rvalid;
   logic next_obj_err;
   logic sub_known;
   logic sub_writable;

   // Routing table
   logic [7:0] route_table [ROUTE_ENTRIES];
   logic [7:0] next_route_table [ROUTE_ENTRIES];

   // Datapath
   logic [31:0] proc_word;
   logic [31:0] routed_word;
   logic route_active;
   logic [31:0] next_state_word;
   logic [3:0] next_sf_out;
   logic [31:0] next_diff_out;

   always_comb begin
      sub_known = (obj_subindex <= SUB_ROUTE_EN);
      sub_writable = sub_known && obj_subindex != SUB_HIGHEST && obj_subindex != SUB_RAW;
      next_sfe = special_function_enable_mask;
      next_inv = polarity_invert_mask;
      next_fen = override_enable_mask;
      next_fval = override_value_word;
      next_range = input_range_choice;
      next_diff = differential_mode_mask;
      next_route_on = source_mapping_on;
      if (obj_wr && sub_writable) begin
         case (obj_subindex)
            SUB_SF_ENABLE: next_sfe = obj_wdata;
            SUB_INVERT: next_inv = obj_wdata;
            SUB_FORCE_EN: next_fen = obj_wdata;
            SUB_FORCE_VAL: next_fval = obj_wdata;
            SUB_RANGE: next_range = obj_wdata;
            SUB_DIFF: next_diff = obj_wdata;
            SUB_ROUTE_EN: next_route_on = obj_wdata;
            default: next_route_on = source_mapping_on;
         endcase
      end
      next_obj_rdata = obj_rdata;
      next_obj_rvalid = obj_rd && sub_known;
      next_obj_err = (obj_rd && !sub_known) || (obj_wr && !sub_writable);
      if (obj_rd) begin
         case (obj_subindex)
            SUB_HIGHEST: next_obj_rdata = {24'h00_0000, HIGHEST_ENTRY_RESET};
            SUB_SF_ENABLE: next_obj_rdata = special_function_enable_mask;
            SUB_INVERT: next_obj_rdata = polarity_invert_mask;
            SUB_FORCE_EN: next_obj_rdata = override_enable_mask;
            SUB_FORCE_VAL: next_obj_rdata = override_value_word;
            SUB_RAW: next_obj_rdata = unprocessed_input_levels; // [RULE_10]
            SUB_RANGE: next_obj_rdata = input_range_choice;
            SUB_DIFF: next_obj_rdata = differential_mode_mask;
            SUB_ROUTE_EN: next_obj_rdata = source_mapping_on;
            default: next_obj_rdata = WORD_RESET;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         special_function_enable_mask <= WORD_RESET;
         polarity_invert_mask <= WORD_RESET;
         override_enable_mask <= WORD_RESET;
         override_value_word <= WORD_RESET;
         input_range_choice <= WORD_RESET;
         differential_mode_mask <= WORD_RESET;
         source_mapping_on <= WORD_RESET;
         obj_rdata <= WORD_RESET;
         obj_rvalid <= 1'b0;
         obj_err <= 1'b0;
      end else begin
         special_function_enable_mask <= next_sfe;
         polarity_invert_mask <= next_inv;
         override_enable_mask <= next_fen;
         override_value_word <= next_fval;
         input_range_choice <= next_range;
         differential_mode_mask <= next_diff;
         source_mapping_on <= next_route_on;
         obj_rdata <= next_obj_rdata;
         obj_rvalid <= next_obj_rvalid;
         obj_err <= next_obj_err;
      end
   end

   always_comb begin
      for (int i = 0; i < ROUTE_ENTRIES; i++) begin
         next_route_table[i] = route_table[i];
      end
      if (route_wr) begin
         next_route_table[route_bit] = route_code;
      end
   end

   always_ff @(posedge clock) begin
      for (int i = 0; i < ROUTE_ENTRIES; i++) begin
         if (!rst_n) begin
            route_table[i] <= ROUTE_CONST_ZERO;
         end else begin
            route_table[i] <= next_route_table[i];
         end
      end
   end

   // Bit n conditions input n+1
   for (genvar n = 0; n < WORD_W; n++) begin : g_cond
      dic_cond_bit u_cond (
         .raw_level(phys_level[n]),
         .invert(polarity_invert_mask[n]), // [RULE_07]
         .clkdir_use(clkdir_mask[n]),
         .force_en(override_enable_mask[n]),
         .force_val(override_value_word[n]),
         .processed(proc_word[n])
      );
   end

   for (genvar b = 0; b < ROUTE_ENTRIES; b++) begin : g_route
      dic_route_sel u_sel (
         .code(route_table[b]),
         .phys_level(phys_level),
         .hall_level(hall_level),
         .enc_level(enc_level),
         .routed(routed_word[b])
      );
   end

   always_comb begin
      route_active = (source_mapping_on == ROUTE_ON_VALUE); // [RULE_12]
      next_state_word = route_active ? routed_word : proc_word; // [RULE_12]
      // Only the four low enable bits act
      next_sf_out = special_function_enable_mask[3:0] & proc_word[3:0]; // [RULE_01] [RULE_02]
      next_diff_out = differential_mode_mask & DIFF_CAPABLE_MASK; // [RULE_11]
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         unprocessed_input_levels <= WORD_RESET;
         digital_input_state_word <= WORD_RESET;
         neg_limit <= 1'b0;
         pos_limit <= 1'b0;
         home_switch <= 1'b0;
         interlock <= 1'b0;
         diff_mode_out <= WORD_RESET;
         input_range_out <= WORD_RESET;
      end else begin
         unprocessed_input_levels <= phys_level; // [RULE_10]
         digital_input_state_word <= next_state_word;
         neg_limit <= next_sf_out[SF_NEG_LIMIT]; // [RULE_03]
         pos_limit <= next_sf_out[SF_POS_LIMIT]; // [RULE_03]
         home_switch <= next_sf_out[SF_HOME]; // [RULE_03]
         interlock <= next_sf_out[SF_INTERLOCK]; // [RULE_03]
         diff_mode_out <= next_diff_out;
         input_range_out <= input_range_choice;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_direct_plain0;
      !route_active && !override_enable_mask[0] && !clkdir_mask[0];
   endsequence

   sequence s_write_invert;
      obj_wr && obj_subindex == SUB_INVERT;
   endsequence

   sequence s_read_invert;
      obj_rd && obj_subindex == SUB_INVERT;
   endsequence

   a_sf_disabled: assert property (!special_function_enable_mask[0] |=> !neg_limit) // [RULE_01]
      else $error("neg limit active while its function is off");
   a_sf_upper_ignored: assert property ( // [RULE_02]
      special_function_enable_mask[3:0] == 4'h0
      |=> {neg_limit, pos_limit, home_switch, interlock} == 4'h0)
      else $error("upper enable bits changed special functions");
   a_sf_home_map: assert property ( // [RULE_03]
      (special_function_enable_mask[SF_HOME] && proc_word[SF_HOME]) |=> home_switch)
      else $error("home switch not mapped to enable bit 2");
   a_polarity_normal: assert property ( // [RULE_05]
      (s_direct_plain0 and !polarity_invert_mask[0])
      |=> digital_input_state_word[0] == $past(phys_level[0]))
      else $error("normally open input not reported directly");
   a_polarity_inverted: assert property ( // [RULE_07]
      (s_direct_plain0 and polarity_invert_mask[0])
      |=> digital_input_state_word[0] == !$past(phys_level[0]))
      else $error("invert bit 0 did not invert input 1");
   a_clkdir_no_invert: assert property ( // [RULE_06]
      (!route_active && clkdir_mask[1] && !override_enable_mask[1])
      |=> digital_input_state_word[1] == $past(phys_level[1]))
      else $error("clock/direction input was inverted");
   a_force_wins: assert property ( // [RULE_14]
      (!route_active && override_enable_mask[2])
      |=> digital_input_state_word[2] == $past(override_value_word[2]))
      else $error("forced value not used");
   a_raw_follows: assert property ( // [RULE_10]
      ##1 unprocessed_input_levels == $past(phys_level))
      else $error("raw word differs from input levels");
   a_diff_capable: assert property ( // [RULE_11]
      ##1 diff_mode_out == ($past(differential_mode_mask) & DIFF_CAPABLE_MASK))
      else $error("differential mode on an incapable input");
   a_route_const_one: assert property ( // [RULE_13]
      (route_active && route_table[1] == ROUTE_CONST_ONE) |=> digital_input_state_word[1])
      else $error("code 80 did not give constant 1");
   a_route_const_zero: assert property ( // [RULE_13]
      (route_active && route_table[0] == ROUTE_CONST_ZERO) |=> !digital_input_state_word[0])
      else $error("code 00 did not give constant 0");
   a_invert_readback: assert property ( // [RULE_07]
      (s_write_invert ##1 (s_read_invert and !obj_wr))
      |=> obj_rvalid && obj_rdata == $past(obj_wdata, 2))
      else $error("invert word readback wrong");
   a_sf_pos_off: assert property ( // [RULE_01]
      !special_function_enable_mask[SF_POS_LIMIT] |=> !pos_limit)
      else $error("pos limit active while its function is off");
   a_sf_neg_map: assert property ( // [RULE_03]
      (special_function_enable_mask[SF_NEG_LIMIT] && proc_word[SF_NEG_LIMIT]) |=> neg_limit)
      else $error("neg limit not mapped to enable bit 0");
   a_sf_pos_map: assert property ( // [RULE_03]
      (special_function_enable_mask[SF_POS_LIMIT] && proc_word[SF_POS_LIMIT]) |=> pos_limit)
      else $error("pos limit not mapped to enable bit 1");
   a_sf_interlock_map: assert property ( // [RULE_03]
      (special_function_enable_mask[SF_INTERLOCK] && proc_word[SF_INTERLOCK]) |=> interlock)
      else $error("interlock not mapped to enable bit 3");
   a_force_word: assert property ( // [RULE_09]
      !route_active |=> (digital_input_state_word & $past(override_enable_mask))
         == ($past(override_value_word) & $past(override_enable_mask)))
      else $error("forced bits differ from the force value word");
   a_raw_write_refused: assert property ( // [RULE_10]
      (obj_wr && obj_subindex == SUB_RAW) |=> obj_err)
      else $error("write to raw word not refused");
   a_route_phys: assert property ( // [RULE_13]
      (route_active && route_table[2] == {1'b0, ROUTE_PHYS_FIRST})
      |=> digital_input_state_word[2] == $past(phys_level[0]))
      else $error("code 01 did not select input 1");
   a_route_phys_inv: assert property ( // [RULE_13]
      (route_active && route_table[3] == {1'b1, ROUTE_PHYS_FIRST})
      |=> digital_input_state_word[3] == !$past(phys_level[0]))
      else $error("code 81 did not select inverted input 1");
   a_route_off_direct: assert property ( // [RULE_12]
      (!route_active && !override_enable_mask[4] && !clkdir_mask[4] && !polarity_invert_mask[4])
      |=> digital_input_state_word[4] == $past(phys_level[4]))
      else $error("direct mapping lost while routing is off");
endmodule : dic_input_ctrl
`default_nettype wire

// >>> verification/dic_input_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module dic_input_ctrl_test
   import dic_pkg::*;
;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [31:0] phys_level = 32'h0;
   logic [2:0] hall_level = 3'h0;
   logic [2:0] enc_level = 3'h0;
   logic [31:0] clkdir_mask = 32'h0;
   logic obj_wr = 1'b0;
   logic obj_rd = 1'b0;
   logic [7:0] obj_subindex = 8'h00;
   logic [31:0] obj_wdata = 32'h0;
   logic route_wr = 1'b0;
   logic [4:0] route_bit = 5'h00;
   logic [7:0] route_code = 8'h00;
   logic [31:0] obj_rdata, digital_input_state_word, diff_mode_out, input_range_out;
   logic obj_rvalid, obj_err, neg_limit, pos_limit, home_switch, interlock;
   logic [31:0] ph, cd, iv, fe, fv, sf, df, rg;
   logic [7:0] codes [10] = '{8'h00, 8'h80, 8'h01, 8'h81, 8'h41,
      8'hC3, 8'h44, 8'hC6, 8'h10, 8'h90};
   int err_count = 0;
   int checked = 0;

   always #2 clock = ~clock;

   dic_input_ctrl u_dut (.clock(clock), .rst_n(rst_n), .phys_level(phys_level),
      .hall_level(hall_level), .enc_level(enc_level), .clkdir_mask(clkdir_mask),
      .obj_wr(obj_wr), .obj_rd(obj_rd), .obj_subindex(obj_subindex), .obj_wdata(obj_wdata),
      .obj_rdata(obj_rdata), .obj_rvalid(obj_rvalid), .obj_err(obj_err),
      .route_wr(route_wr), .route_bit(route_bit), .route_code(route_code),
      .digital_input_state_word(digital_input_state_word), .neg_limit(neg_limit),
      .pos_limit(pos_limit), .home_switch(home_switch), .interlock(interlock),
      .diff_mode_out(diff_mode_out), .input_range_out(input_range_out));

   task automatic final_report;
      $display("checked=%0d err_count=%0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Processed level: invert unless clock/direction, then override
   function automatic logic [31:0] proc_exp();
      return (((ph ^ (iv & ~cd)) & ~fe) | (fv & fe));
   endfunction : proc_exp

   function automatic logic [31:0] route_exp();
      logic [31:0] w;
      logic [6:0] s;
      logic v;
      for (int b = 0; b < 32; b++) begin
         s = (b < 10) ? codes[b][6:0] : 7'h00;
         v = 1'b0;
         if (s >= 7'h01 && s <= 7'h10) v = ph[s - 7'h01];
         if (s >= 7'h41 && s <= 7'h43) v = hall_level[s - 7'h41];
         if (s >= 7'h44 && s <= 7'h46) v = enc_level[s - 7'h44];
         w[b] = (b < 10 && codes[b][7]) ? ~v : v;
      end
      return w;
   endfunction : route_exp

   task automatic obj_op(input logic wr, input logic [7:0] sub, input logic [31:0] d,
                         input logic bad, input logic [31:0] exp);
      int n;
      @(posedge clock);
      obj_wr <= wr;
      obj_rd <= !wr;
      obj_subindex <= sub;
      obj_wdata <= d;
      @(posedge clock);
      obj_wr <= 1'b0;
      obj_rd <= 1'b0;
      #1;
      n = 0;
      if (!wr) begin
         while (obj_rvalid !== 1'b1 && obj_err !== 1'b1 && n < 4) begin
            @(posedge clock);
            #1;
            n++;
         end
         if (n == 4) begin
            err_count++;
            final_report();
         end
      end
      check("obj_err", {31'h0, obj_err}, {31'h0, bad});
      check("obj_rvalid", {31'h0, obj_rvalid}, {31'h0, !wr && !bad});
      if (!wr && !bad) check("obj_rdata", obj_rdata, exp);
   endtask : obj_op

   task automatic settle;
      repeat (2) @(posedge clock);
      #1;
   endtask : settle

   task automatic drive_inputs;
      @(posedge clock);
      phys_level <= ph;
      clkdir_mask <= cd;
      hall_level <= 3'($urandom);
      enc_level <= 3'($urandom);
   endtask : drive_inputs

   initial begin
      void'($urandom(14));
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      #1;
      check("state_after_reset", digital_input_state_word, 32'h0);
      obj_op(1'b0, SUB_HIGHEST, 32'h0, 1'b0, 32'h0000_0008);
      for (int s = 1; s <= 8; s++) obj_op(1'b0, 8'(s), 32'h0, 1'b0, 32'h0);
      obj_op(1'b1, SUB_HIGHEST, 32'hFFFF_FFFF, 1'b1, 32'h0);
      obj_op(1'b1, SUB_RAW, 32'hFFFF_FFFF, 1'b1, 32'h0);
      obj_op(1'b0, 8'h09, 32'h0, 1'b1, 32'h0);
      obj_op(1'b1, 8'h09, 32'h0, 1'b1, 32'h0);
      obj_op(1'b0, SUB_HIGHEST, 32'h0, 1'b0, 32'h0000_0008);
      for (int i = 0; i < 24; i++) begin
         ph = $urandom;
         cd = (i == 0) ? 32'h0 : $urandom & $urandom;
         iv = (i == 0) ? 32'hFFFF_FFFF : $urandom;
         fe = (i == 1) ? 32'hFFFF_FFFF : ((i == 0) ? 32'h0 : $urandom);
         fv = $urandom;
         // Four low special-function enable bits cleared on odd passes
         sf = (i % 2) ? ($urandom & 32'hFFFF_FFF0) : $urandom;
         df = $urandom;
         rg = $urandom;
         drive_inputs();
         obj_op(1'b1, SUB_SF_ENABLE, sf, 1'b0, 32'h0);
         obj_op(1'b1, SUB_INVERT, iv, 1'b0, 32'h0);
         // Write then read back in the very next cycle
         @(posedge clock);
         obj_wr <= 1'b1;
         obj_subindex <= SUB_INVERT;
         obj_wdata <= iv;
         @(posedge clock);
         obj_wr <= 1'b0;
         obj_rd <= 1'b1;
         @(posedge clock);
         obj_rd <= 1'b0;
         #1;
         check("invert_b2b", obj_rdata, iv);
         check("invert_b2b_valid", {31'h0, obj_rvalid}, 32'h0000_0001);
         obj_op(1'b1, SUB_FORCE_EN, fe, 1'b0, 32'h0);
         obj_op(1'b1, SUB_FORCE_VAL, fv, 1'b0, 32'h0);
         obj_op(1'b1, SUB_RANGE, rg, 1'b0, 32'h0);
         obj_op(1'b1, SUB_DIFF, df, 1'b0, 32'h0);
         settle();
         check("state_word", digital_input_state_word, proc_exp());
         check("forced", digital_input_state_word & fe, fv & fe);
         check("special", {28'h0, interlock, home_switch, pos_limit, neg_limit},
               {28'h0, sf[3:0] & 4'(proc_exp())});
         check("diff_mode_out", diff_mode_out, df & DIFF_CAPABLE_MASK);
         check("input_range_out", input_range_out, rg);
         obj_op(1'b0, SUB_RAW, 32'h0, 1'b0, ph);
         obj_op(1'b0, SUB_SF_ENABLE, 32'h0, 1'b0, sf);
      end
      // Back-to-back table writes, strobe held high
      for (int b = 0; b < 10; b++) begin
         @(posedge clock);
         route_wr <= 1'b1;
         route_bit <= 5'(b);
         route_code <= codes[b];
      end
      @(posedge clock);
      route_wr <= 1'b0;
      obj_op(1'b1, SUB_ROUTE_EN, 32'h0000_0002, 1'b0, 32'h0);
      settle();
      check("state_route_off", digital_input_state_word, proc_exp());
      obj_op(1'b1, SUB_ROUTE_EN, ROUTE_ON_VALUE, 1'b0, 32'h0);
      obj_op(1'b0, SUB_ROUTE_EN, 32'h0, 1'b0, ROUTE_ON_VALUE);
      for (int i = 0; i < 8; i++) begin
         ph = $urandom;
         drive_inputs();
         settle();
         check("state_routed", digital_input_state_word, route_exp());
      end
      final_report();
   end
endmodule : dic_input_ctrl_test
`default_nettype wire
